// file: logic/css_map.vh
// register offsets, field positions and reset values of the select router
`ifndef CSS_MAP_VH
`define CSS_MAP_VH
`define CSS_ADDR_STRETCH 8'h5A
`define CSS_ADDR_GEN2_CTRL 8'h5F
`define CSS_ADDR_ROUTE 8'h60
`define CSS_STRETCH_RESET 8'h00
`define CSS_GEN2_CTRL_RESET 8'h00
`define CSS_ROUTE_RESET 8'h00
`define CSS_IO_FIELD_HI 7
`define CSS_IO_FIELD_LO 6
`define CSS_G1_FIELD_HI 5
`define CSS_G1_FIELD_LO 4
`define CSS_G2_FIELD_HI 3
`define CSS_G2_FIELD_LO 2
`define CSS_PR_FIELD_HI 1
`define CSS_PR_FIELD_LO 0
`define CSS_G2DP_BIT 0
`define CSS_G1DP_BIT 1
`define CSS_GEN_ONE_FEEDS_GEN_TWO_PIN_BIT 0
`endif

// file: logic/css_sync3.v
// three-stage input synchroniser with agreement of stages two and three
`timescale 1ns/1ps
`default_nettype none
module css_sync3 (
  input wire clk,
  input wire reset,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  // s1 feeds only s2; output moves once s2 and s3 agree
  always @(posedge clk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // css_sync3
`default_nettype wire

// file: logic/css_route.v
// combinational chip-select routing between the three select sources
`timescale 1ns/1ps
`default_nettype none
module css_route (
  input wire hit_prog,
  input wire hit_gen1,
  input wire hit_gen2,
  input wire gen_one_feeds_gen_two_pin,
  input wire gen_one_feeds_program_pin,
  input wire gen_two_feeds_program_pin,
  output wire sel_prog,
  output wire sel_gen1,
  output wire sel_gen2
);
  // general 1 goes to program when both routes are set, never to general 2
  wire g1_to_g2;
  assign g1_to_g2 = gen_one_feeds_gen_two_pin & ~gen_one_feeds_program_pin;
  // program pin ORs in the routed general selects
  assign sel_prog = hit_prog
    | (gen_two_feeds_program_pin & hit_gen2)
    | (gen_one_feeds_program_pin & hit_gen1);
  // general 2 silenced when fed to program; takes general 1 if routed
  assign sel_gen2 = ~gen_two_feeds_program_pin
    & (hit_gen2 | (g1_to_g2 & hit_gen1));
  // general 1 pin only stays its own when routed nowhere live
  assign sel_gen1 = hit_gen1 & ~gen_one_feeds_program_pin
    & ~(gen_one_feeds_gen_two_pin & ~gen_two_feeds_program_pin);
endmodule // css_route
`default_nettype wire

// file: logic/css_stretch_top.v
// chip-select routing and bus clock stretch for the expansion bus
// Functional notes
// - g2-drives-program set: program pin carries program OR general 2.
// - g2-drives-program clear: general 2 decode leaves program pin alone.
// - all routing clear: each pin follows only its own range.
// - only g1-drives-program: program pin takes general 1; g1 pin silent.
// - both drives-program set: program pin takes all; general pins silent.
// - g1-to-g2 and g1-to-program: g1 goes to program only.
// - g1-to-g2, g2-to-program: g1 own pin, program takes general 2.
// - selects follow E clock; stretched access holds E high extra cycles.
// - stretch applies only to the selected range's accesses.
// - other clocks keep running during a stretch.
// - stretch field is a binary count of extra cycles, 0 to 3.
// - stretch register fields io 7:6, g1 5:4, g2 3:2, prog 1:0, reset 0.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"
module css_stretch_top #(
  parameter E_HALF = 2
) (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire access_req,
  input wire hit_prog,
  input wire hit_gen1,
  input wire hit_gen2,
  input wire hit_io,
  input wire ext_hold,
  output reg e_clk,
  output reg program_select_pin,
  output reg general_select_one_pin,
  output reg general_select_two_pin,
  output reg io_select_pin,
  output reg stretching,
  output reg access_done,
  output reg tick
);
  localparam ST_IDLE = 2'd0;
  localparam ST_LOW = 2'd1;
  localparam ST_HIGH = 2'd2;
  localparam ST_STR = 2'd3;

  reg [7:0] select_clock_stretch;
  reg [7:0] general_select_two_control;
  reg [7:0] route_ctrl;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] phase;
  reg [1:0] extra;
  reg [1:0] next_extra;
  reg [7:0] tick_cnt;
  reg lp;
  reg lg1;
  reg lg2;
  reg lio;
  wire hold_sync;
  wire sel_prog;
  wire sel_gen1;
  wire sel_gen2;
  wire gen_two_feeds_program_pin;
  wire gen_one_feeds_program_pin;
  wire gen_one_feeds_gen_two_pin;
  wire phase_end;
  wire cur_p;
  wire cur_g1;
  wire cur_g2;
  wire cur_io;
  wire [1:0] io_stretch_field;
  wire [1:0] gen_one_stretch_field;
  wire [1:0] gen_two_stretch_field;
  wire [1:0] program_stretch_field;

  // field decode of the stretch, general 2 control and route registers
  assign io_stretch_field =
    select_clock_stretch[`CSS_IO_FIELD_HI:`CSS_IO_FIELD_LO];
  assign gen_one_stretch_field =
    select_clock_stretch[`CSS_G1_FIELD_HI:`CSS_G1_FIELD_LO];
  assign gen_two_stretch_field =
    select_clock_stretch[`CSS_G2_FIELD_HI:`CSS_G2_FIELD_LO];
  assign program_stretch_field =
    select_clock_stretch[`CSS_PR_FIELD_HI:`CSS_PR_FIELD_LO];
  assign gen_two_feeds_program_pin =
    general_select_two_control[`CSS_G2DP_BIT];
  assign gen_one_feeds_program_pin = route_ctrl[`CSS_G1DP_BIT];
  assign gen_one_feeds_gen_two_pin = route_ctrl[`CSS_GEN_ONE_FEEDS_GEN_TWO_PIN_BIT];
  assign phase_end = (phase == E_HALF - 1);

  // at the request edge the latches still hold the last access, so the
  // first select cycle must look at the live hits instead
  assign cur_p = (state == ST_IDLE) ? hit_prog : lp;
  assign cur_g1 = (state == ST_IDLE) ? hit_gen1 : lg1;
  assign cur_g2 = (state == ST_IDLE) ? hit_gen2 : lg2;
  assign cur_io = (state == ST_IDLE) ? hit_io : lio;

  // external wait line comes from a pin, so it is synchronised
  css_sync3 u_hold (
    .clk(clk),
    .reset(reset),
    .din(ext_hold),
    .dout(hold_sync)
  );

  css_route u_route (
    .hit_prog(cur_p),
    .hit_gen1(cur_g1),
    .hit_gen2(cur_g2),
    .gen_one_feeds_gen_two_pin(gen_one_feeds_gen_two_pin),
    .gen_one_feeds_program_pin(gen_one_feeds_program_pin),
    .gen_two_feeds_program_pin(gen_two_feeds_program_pin),
    .sel_prog(sel_prog),
    .sel_gen1(sel_gen1),
    .sel_gen2(sel_gen2)
  );

  // register writes; all control resets to zero
  always @(posedge clk) begin
    if (reset) begin
      select_clock_stretch <= `CSS_STRETCH_RESET;
      general_select_two_control <= `CSS_GEN2_CTRL_RESET;
      route_ctrl <= `CSS_ROUTE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `CSS_ADDR_STRETCH: select_clock_stretch <= reg_wdata;
        `CSS_ADDR_GEN2_CTRL: general_select_two_control <= reg_wdata;
        `CSS_ADDR_ROUTE: route_ctrl <= {6'h00, reg_wdata[1:0]};
        default: ;
      endcase
    end
  end

  // read data valid the cycle after the strobe; unmapped reads zero
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSS_ADDR_STRETCH: reg_rdata <= select_clock_stretch;
        `CSS_ADDR_GEN2_CTRL: reg_rdata <= general_select_two_control;
        `CSS_ADDR_ROUTE: reg_rdata <= route_ctrl;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // free-running timebase; never paused by a stretch
  always @(posedge clk) begin
    if (reset) begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == E_HALF - 1) ? 8'h00 : tick_cnt + 8'h01;
      tick <= (tick_cnt == E_HALF - 1);
    end
  end

  // bus cycle sequencing and stretch selection
  always @* begin
    next_state = state;
    next_extra = extra;
    case (state)
      ST_IDLE: begin
        if (access_req) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (phase_end) begin
          next_state = ST_HIGH;
          // stretch picks only the range actually hit
          if (lp) begin
            next_extra = program_stretch_field;
          end else if (lg1) begin
            next_extra = gen_one_stretch_field;
          end else if (lg2) begin
            next_extra = gen_two_stretch_field;
          end else if (lio) begin
            next_extra = io_stretch_field;
          end else begin
            next_extra = 2'b00;
          end
        end
      end
      ST_HIGH: begin
        if (phase_end && !hold_sync) begin
          next_state = (extra != 2'b00) ? ST_STR : ST_IDLE;
        end
      end
      ST_STR: begin
        // each extra bus cycle is two half periods of high E
        if (phase == 2 * E_HALF - 1) begin
          if (extra == 2'b01) begin
            next_state = ST_IDLE;
          end
          next_extra = extra - 2'b01;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state, phase counter, latched hits and registered pins
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      phase <= 8'h00;
      extra <= 2'b00;
      lp <= 1'b0;
      lg1 <= 1'b0;
      lg2 <= 1'b0;
      lio <= 1'b0;
      e_clk <= 1'b0;
      program_select_pin <= 1'b0;
      general_select_one_pin <= 1'b0;
      general_select_two_pin <= 1'b0;
      io_select_pin <= 1'b0;
      stretching <= 1'b0;
      access_done <= 1'b0;
    end else begin
      state <= next_state;
      extra <= next_extra;
      if (next_state != state || (state == ST_STR &&
          phase == 2 * E_HALF - 1)) begin
        phase <= 8'h00;
      end else if (state != ST_IDLE &&
          !(state == ST_HIGH && phase_end)) begin
        // a held high phase parks at its last count instead of wrapping
        phase <= phase + 8'h01;
      end
      // address hits are captured at the start so selects stay stable
      if (state == ST_IDLE && access_req) begin
        lp <= hit_prog;
        lg1 <= hit_gen1;
        lg2 <= hit_gen2;
        lio <= hit_io;
      end
      // selects and E change only with the bus cycle
      e_clk <= (next_state == ST_HIGH) || (next_state == ST_STR);
      program_select_pin <= (next_state != ST_IDLE) && sel_prog;
      general_select_one_pin <= (next_state != ST_IDLE) && sel_gen1;
      general_select_two_pin <= (next_state != ST_IDLE) && sel_gen2;
      io_select_pin <= (next_state != ST_IDLE) && cur_io;
      stretching <= (next_state == ST_STR);
      access_done <= (state != ST_IDLE) && (next_state == ST_IDLE);
    end
  end
endmodule // css_stretch_top
`default_nettype wire

// file: tb/css_stretch_chk.sv
// port checker for the select router and E stretch
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"
module css_stretch_chk #(parameter int E_HALF = 2) (
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire e_clk,
  input wire program_select_pin,
  input wire general_select_one_pin,
  input wire general_select_two_pin,
  input wire io_select_pin,
  input wire stretching,
  input wire access_done,
  input wire tick
);
  logic [7:0] str_sh;
  logic [1:0] rt_sh;
  logic g2_sh;
  // shadow registers stand in for internal taps we cannot see
  always_ff @(posedge clk) begin
    if (reset) begin
      str_sh <= 8'h00;
      rt_sh <= 2'h0;
      g2_sh <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `CSS_ADDR_STRETCH) str_sh <= reg_wdata;
      if (reg_addr == `CSS_ADDR_ROUTE) rt_sh <= reg_wdata[1:0];
      if (reg_addr == `CSS_ADDR_GEN2_CTRL) g2_sh <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  g1_silent_a: assert property (
    rt_sh[1] || (rt_sh[0] && !g2_sh) |-> !general_select_one_pin)
    else $error("general one pin asserted while routed away");
  g2_silent_a: assert property (
    g2_sh |-> !general_select_two_pin)
    else $error("general two pin asserted while routed away");
  stretch_rd_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `CSS_ADDR_STRETCH |->
    reg_rdata == $past(str_sh))
    else $error("stretch register read wrong");
  done_pulse_a: assert property (
    access_done |=> !access_done) else $error("done wider than one cycle");
  sel_drop_a: assert property (
    access_done |-> !e_clk && !(program_select_pin ||
    general_select_one_pin || general_select_two_pin || io_select_pin))
    else $error("selects or E still high at access end");
  stretch_e_a: assert property (
    stretching |-> e_clk) else $error("E low during stretch");
  // one extra bus cycle is two E halves, four clocks at E_HALF of 2
  stretch_len_a: assert property (
    $rose(stretching) |-> stretching[*4]) else $error("stretch too short");
  tick_run_a: assert property (
    tick |-> ##E_HALF tick) else $error("tick stalled");
endmodule // css_stretch_chk
bind css_stretch_top css_stretch_chk #(.E_HALF(E_HALF)) u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e_clk(e_clk),
  .program_select_pin(program_select_pin),
  .general_select_one_pin(general_select_one_pin),
  .general_select_two_pin(general_select_two_pin),
  .io_select_pin(io_select_pin), .stretching(stretching),
  .access_done(access_done), .tick(tick));
`default_nettype wire

// file: tb/css_slow_dev.sv
// slow peripheral that holds the bus through the hold pin
`timescale 1ns/1ps
`default_nettype none
module css_slow_dev (
  input wire clk,
  input wire sel,
  input wire [3:0] hold_len,
  output logic ext_hold
);
  logic [3:0] left = 4'h0;
  logic sel_d = 1'b0;
  // hold starts as a select rises; zero length answers promptly
  always @(posedge clk) begin
    sel_d <= sel;
    if (sel && !sel_d) left <= hold_len;
    else if (left != 4'h0) left <= left - 4'h1;
  end
  assign ext_hold = (left != 4'h0);
endmodule // css_slow_dev
`default_nettype wire

// file: tb/tb_chip_select_routing_and_stretch.sv
// self-checking bench for the select router and E stretch
`timescale 1ns/1ps
`default_nettype none
`include "css_map.vh"
module tb_chip_select_routing_and_stretch;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic access_req = 1'b0;
  logic [3:0] hits = 4'h0; // prog, gen1, gen2, io
  logic [3:0] hold_len = 4'h0;
  logic [7:0] reg_rdata;
  logic e_clk, ext_hold, stretching, access_done;
  logic [3:0] pins;
  logic [3:0] seen = 4'h0;
  logic [7:0] cnt = 8'h00;
  logic rd_d = 1'b0;
  logic [7:0] qr[$];
  logic [11:0] qa[$];
  logic [11:0] ex;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'h0222DD63;
  int sh[4] = '{0, 4, 2, 6};
  css_stretch_top #(.E_HALF(2)) dut (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .access_req(access_req),
    .hit_prog(hits[3]), .hit_gen1(hits[2]), .hit_gen2(hits[1]),
    .hit_io(hits[0]), .ext_hold(ext_hold), .e_clk(e_clk),
    .program_select_pin(pins[3]), .general_select_one_pin(pins[2]),
    .general_select_two_pin(pins[1]), .io_select_pin(pins[0]),
    .stretching(stretching), .access_done(access_done), .tick());
  css_slow_dev peer (.clk(clk), .sel(|pins), .hold_len(hold_len),
    .ext_hold(ext_hold));
  initial forever #12.5 clk = ~clk;
  task automatic give_verdict();
    // a note left on either queue is a result that never showed
    if (qa.size() != 0 || qr.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    qr.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // count FF in the note means a held access of unknown length
  task automatic acc(input logic [3:0] h, input logic [11:0] e);
    int k;
    qa.push_back(e);
    @(posedge clk);
    hits <= h;
    access_req <= 1'b1;
    @(posedge clk);
    access_req <= 1'b0;
    k = 0;
    while (access_done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) n_mismatch++;
  endtask
  // expected pins for one hit under routing {g1->g2, g1->prog, g2->prog}
  function automatic logic [3:0] route(input logic [2:0] r,
                                       input logic [3:0] h);
    logic [3:0] p;
    p = {h[3], 2'b00, h[0]};
    if (h[1]) p |= r[0] ? 4'h8 : 4'h2;
    if (h[2]) p |= r[1] ? 4'h8 : (r[2] && !r[0]) ? 4'h2 : 4'h4;
    return p;
  endfunction
  // results are matched in arrival order against the driver's notes
  always @(posedge clk) begin
    rd_d <= reg_rd;
    seen <= access_done ? 4'h0 : seen | pins;
    cnt <= access_done ? 8'h00 : cnt + {7'h00, stretching};
    if (rd_d) chk({4'h0, reg_rdata}, {4'h0, qr.pop_front()});
    if (access_done === 1'b1) begin
      ex = qa.pop_front();
      chk({seen, ex[7:0] == 8'hFF ? 8'hFF : cnt}, ex);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [31:0] rv;
    logic [7:0] s;
    logic [7:0] n;
    logic [3:0] h;
    logic [2:0] r;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(`CSS_ADDR_STRETCH, 8'h00);
    rd(`CSS_ADDR_ROUTE, 8'h00);
    rd(8'h33, 8'h00);
    // every routing row, every hit kind, random stretch fields
    for (int i = 0; i < 8; i++) begin
      r = i[2:0];
      rv = $random(seed);
      s = rv[7:0];
      wr(`CSS_ADDR_STRETCH, s);
      wr(`CSS_ADDR_ROUTE, {6'h00, r[1], r[2]});
      wr(`CSS_ADDR_GEN2_CTRL, {7'h00, r[0]});
      rd(`CSS_ADDR_STRETCH, s);
      for (int j = 0; j < 4; j++) begin
        h = 4'h8 >> j;
        n = (s >> sh[j]) & 8'h03;
        acc(h, {route(r, h), n << 2});
      end
    end
    hold_len <= 4'h6;
    acc(4'h8, {4'h8, 8'hFF});
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule // tb_chip_select_routing_and_stretch
`default_nettype wire
